// ---- dhs_pkg.sv ----
// package: opcodes, latencies and carriers for the dual halfword saturating alu
package dhs_pkg;
  localparam int DHS_LANE_W = 16;
  localparam int DHS_WORD_W = 32;
  localparam int DHS_LAT_ALU = 2;
  localparam int DHS_LAT_MUL = 3;
  localparam int DHS_GUARD_BIT = 0;
  localparam logic signed [31:0] DHS_SAT_MAX = 32'sh0000_7fff;
  localparam logic signed [31:0] DHS_SAT_MIN = 32'shffff_8000;
  localparam logic [15:0] DHS_LANE_MAX = 16'h7fff;
  localparam logic [15:0] DHS_LANE_MIN = 16'h8000;
  localparam logic [31:0] DHS_RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    DHS_OP_ABS = 2'h0,
    DHS_OP_ADD = 2'h1,
    DHS_OP_MUL = 2'h2,
    DHS_OP_SUB = 2'h3
  } dhs_op_e;

  typedef struct packed {
    logic valid;
    dhs_op_e op;
    logic guardPresent;
    logic [31:0] guard;
    logic [4:0] destIndex;
    logic [31:0] firstSource;
    logic [31:0] secondSource;
  } dhs_issue_s;

  typedef struct packed {
    logic valid;
    logic [4:0] destIndex;
    logic [31:0] data;
  } dhs_write_s;
endpackage

// ---- dhs_lane.sv ----
// one signed 16-bit lane: abs, add, mul or sub, saturated
`timescale 1ns/1ps
module dhs_lane (
  // operands
  input wire logic [15:0] firstHalf,
  input wire logic [15:0] secondHalf,
  input wire dhs_pkg::dhs_op_e op,
  // result
  output logic [15:0] result
);
  logic signed [31:0] firstExt;
  logic signed [31:0] secondExt;
  logic signed [31:0] sum;
  logic signed [31:0] diff;
  logic signed [31:0] prod;
  logic signed [31:0] absVal;
  logic signed [31:0] raw;
  logic signed [31:0] sat;

  assign firstExt = {{16{firstHalf[15]}}, firstHalf}; // RULE_09
  assign secondExt = {{16{secondHalf[15]}}, secondHalf}; // RULE_09
  assign sum = firstExt + secondExt;
  assign diff = firstExt - secondExt;
  // 16x16 signed product always fits 32 bits, no overflow before clipping
  assign prod = firstExt * secondExt;
  // most negative clips first, then plain negation
  assign absVal = (firstExt == dhs_pkg::DHS_SAT_MIN) ? dhs_pkg::DHS_SAT_MAX : // RULE_02
    (firstExt < 0) ? -firstExt : firstExt; // RULE_01 RULE_03

  assign raw = (op == dhs_pkg::DHS_OP_ABS) ? absVal : // RULE_12
    (op == dhs_pkg::DHS_OP_ADD) ? sum : // RULE_04
    (op == dhs_pkg::DHS_OP_MUL) ? prod : diff; // RULE_05 RULE_06
  assign sat = (raw < dhs_pkg::DHS_SAT_MIN) ? dhs_pkg::DHS_SAT_MIN :
    (raw > dhs_pkg::DHS_SAT_MAX) ? dhs_pkg::DHS_SAT_MAX : raw; // RULE_04 RULE_05 RULE_06
  assign result = sat[15:0]; // RULE_08
endmodule // dhs_lane

// ---- dhs_alu.sv ----
// dual halfword saturating alu: two lanes, pipelined, guarded write-back
// Operation
// [RULE_01] abs of both halfwords, each independent
// [RULE_02] most negative halfword gives 0x7fff
// [RULE_03] non-negative passes, negative is negated
// [RULE_04] add lanes, saturate to signed 16
// [RULE_05] multiply lanes, saturate to signed 16
// [RULE_06] subtract second from first, saturate
// [RULE_07] high with high, low with low
// [RULE_08] upper result bits 31:16, lower 15:0
// [RULE_09] sign-extend halfwords before arithmetic
// [RULE_10] guard bit 0 set enables write
// [RULE_11] no guard means always write; an alu op landing in the same cycle as a mul is dropped
// [RULE_12] selector picks function; abs ignores second
`timescale 1ns/1ps
module dhs_alu #(
  parameter int LAT_ALU = dhs_pkg::DHS_LAT_ALU,
  parameter int LAT_MUL = dhs_pkg::DHS_LAT_MUL
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // issue
  input wire dhs_pkg::dhs_issue_s issue,
  // write-back
  output dhs_pkg::dhs_write_s writeBack
);
  // taps sit at stage latency-2, so both latencies need at least two cycles
  generate
    if (LAT_ALU < 2 || LAT_MUL < LAT_ALU || LAT_MUL > 8) begin : gBadLatency
      $error("dhs_alu: unsupported latency");
    end
  endgenerate

  localparam int DEPTH = LAT_MUL;

  logic [15:0] upperResult;
  logic [15:0] lowerResult;
  logic doWrite;
  logic [31:0] packed32;
  logic isMul;

  // lanes share only the op select, so one lane saturating leaves the other alone
  dhs_lane upperLane ( // RULE_07
    .firstHalf(issue.firstSource[31:16]),
    .secondHalf(issue.secondSource[31:16]),
    .op(issue.op),
    .result(upperResult)
  );
  dhs_lane lowerLane ( // RULE_07
    .firstHalf(issue.firstSource[15:0]),
    .secondHalf(issue.secondSource[15:0]),
    .op(issue.op),
    .result(lowerResult)
  );

  assign doWrite = issue.valid &&
    (!issue.guardPresent || issue.guard[dhs_pkg::DHS_GUARD_BIT]); // RULE_10 RULE_11
  assign packed32 = {upperResult, lowerResult}; // RULE_08
  assign isMul = (issue.op == dhs_pkg::DHS_OP_MUL);

  // delay line; each entry exits at its own latency stage
  logic [DEPTH-1:0] stValid;
  logic [DEPTH-1:0] stMul;
  logic [4:0] stDest [DEPTH];
  logic [31:0] stData [DEPTH];
  logic [DEPTH-1:0] tapAlu;
  logic [DEPTH-1:0] tapMul;
  logic anyTap;
  dhs_pkg::dhs_write_s next_writeBack;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stValid <= '0;
      stMul <= '0;
    end else begin
      stValid <= {stValid[DEPTH-2:0], doWrite};
      stMul <= {stMul[DEPTH-2:0], isMul};
    end
  end

  always_ff @(posedge sys_clk) begin
    stDest[0] <= issue.destIndex;
    stData[0] <= packed32;
    for (int i = 1; i < DEPTH; i++) begin
      stDest[i] <= stDest[i-1];
      stData[i] <= stData[i-1];
    end
  end

  // stage index i holds an op issued i+1 cycles ago; output register adds one more
  // since writeBack is taken from stage latency-2 then registered
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : gTap
      assign tapAlu[g] = (g == LAT_ALU - 2) && stValid[g] && !stMul[g];
      assign tapMul[g] = (g == LAT_MUL - 2) && stValid[g] && stMul[g];
    end
  endgenerate
  assign anyTap = |(tapAlu | tapMul);

  always_comb begin
    next_writeBack = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (tapAlu[i] || tapMul[i]) begin
        next_writeBack.destIndex = stDest[i];
        next_writeBack.data = stData[i];
      end
    end
    next_writeBack.valid = anyTap; // RULE_10 RULE_11
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      writeBack <= '0;
    end else begin
      writeBack <= next_writeBack;
    end
  end
endmodule // dhs_alu

// ---- dhs_alu_properties.sv ----
// port assertions for the dual halfword alu
`timescale 1ns/1ps
module dhs_alu_properties #(
  parameter int LAT_ALU = 2,
  parameter int LAT_MUL = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // issue and write-back
  input wire dhs_pkg::dhs_issue_s issue,
  input wire dhs_pkg::dhs_write_s writeBack
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire go = issue.valid && (!issue.guardPresent || issue.guard[0]);
  wire mul = issue.op == dhs_pkg::DHS_OP_MUL;
  wire [1:0] op = issue.op;
  AST_ALU: assert property (go && !mul |-> ##2 writeBack.valid)
    else $error("alu late");
  AST_MUL: assert property (go && mul |-> ##3 writeBack.valid)
    else $error("mul late");
  AST_OFF: assert property (issue.valid && !go && !mul |-> ##2 !writeBack.valid)
    else $error("guarded write");
  AST_DEST: assert property (go && !mul |-> ##2 writeBack.destIndex == $past(issue.destIndex, 2))
    else $error("dest");
  AST_ABS: assert property (go && op == 2'h0 |-> ##2 !writeBack.data[31] && !writeBack.data[15])
    else $error("abs sign");
  AST_PASS: assert property (go && op == 2'h0 && !issue.firstSource[31] |-> ##2
    writeBack.data[31:16] == $past(issue.firstSource[31:16], 2)) else $error("abs pass");
  AST_SUB: assert property (go && op == 2'h3 && issue.firstSource == issue.secondSource |-> ##2
    writeBack.data == 32'h0) else $error("sub self");
  AST_LANE: assert property (go && op == 2'h1 && issue.secondSource[15:0] == 16'h0 |-> ##2
    writeBack.data[15:0] == $past(issue.firstSource[15:0], 2)) else $error("lane");
endmodule // dhs_alu_properties

// ---- dhs_regfile.sv ----
// register file partner: takes write-backs
`timescale 1ns/1ps
module dhs_regfile (
  // write-back
  input wire logic sys_clk,
  input wire dhs_pkg::dhs_write_s writeBack,
  // read port
  input wire logic [4:0] rdIndex,
  output logic [31:0] rdData
);
  logic [31:0] regs [32] = '{default: 32'h0};
  always @(posedge sys_clk) begin
    if (writeBack.valid) regs[writeBack.destIndex] <= writeBack.data;
  end
  assign rdData = regs[rdIndex];
endmodule // dhs_regfile

// ---- test_dhs_alu.sv ----
// self-checking bench for the dual halfword alu
`timescale 1ns/1ps
module test_dhs_alu;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  dhs_pkg::dhs_issue_s issue = '0;
  dhs_pkg::dhs_write_s writeBack;
  logic [4:0] rdIndex = 5'h0;
  logic [31:0] rdData;
  int fails = 0;
  int checked = 0;
  always #10 sys_clk = ~sys_clk;
  dhs_alu u_dhs_alu (.sys_clk(sys_clk), .reset(reset), .issue(issue), .writeBack(writeBack));
  dhs_regfile u_dhs_regfile (.sys_clk(sys_clk), .writeBack(writeBack), .rdIndex(rdIndex), .rdData(rdData));
  task check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t %h %h", $time, s, e);
    end
  endtask
  task end_of_test;
    if (fails == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // g: present, bit 0; off guard is nonzero so only bit 0 can decide
  task run(input logic [1:0] o, input logic [1:0] g, input logic [4:0] d,
           input logic [31:0] a, input logic [31:0] b, input logic [31:0] x);
    logic w;
    w = !g[1] || g[0];
    @(posedge sys_clk);
    issue <= '{1'b1, dhs_pkg::dhs_op_e'(o), g[1], {31'h7fffffff, g[0]}, d, a, b};
    rdIndex <= d;
    @(posedge sys_clk);
    issue.valid <= 1'b0;
    repeat (o == 2'h2 ? 2 : 1) @(posedge sys_clk);
    #1;
    check({31'h0, writeBack.valid}, {31'h0, w});
    check(writeBack.data, w ? x : 32'h0);
    check({27'h0, writeBack.destIndex}, w ? {27'h0, d} : 32'h0);
    @(posedge sys_clk);
    #1;
    check(rdData, x);
  endtask
  task t_abs;
    run(2'h0, 2'h3, 5'h1, 32'h80008001, 32'h12345678, 32'h7fff7fff);
    run(2'h0, 2'h0, 5'h2, 32'h0032ffff, 32'h0, 32'h00320001);
  endtask
  task t_add;
    run(2'h1, 2'h0, 5'h3, 32'h7fff8000, 32'h00010000, 32'h7fff8000);
    run(2'h1, 2'h2, 5'h3, 32'h12340032, 32'h00010002, 32'h7fff8000);
  endtask
  task t_mul;
    run(2'h2, 2'h0, 5'h4, 32'h80000002, 32'h00024000, 32'h80007fff);
    run(2'h2, 2'h0, 5'h5, 32'h08000003, 32'h00108001, 32'h7fff8000);
  endtask
  task t_sub;
    run(2'h3, 2'h0, 5'h6, 32'h00018001, 32'h80010002, 32'h7fff8000);
    run(2'h3, 2'h3, 5'h7, 32'h80007fff, 32'h80007fff, 32'h0);
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    t_abs();
    t_add();
    t_mul();
    t_sub();
    end_of_test();
  end
endmodule // test_dhs_alu
bind dhs_alu dhs_alu_properties #(.LAT_ALU(LAT_ALU), .LAT_MUL(LAT_MUL)) u_dhs_alu_properties (
  .sys_clk(sys_clk), .reset(reset), .issue(issue), .writeBack(writeBack));
